// [pkg/atrc_consts.vh]
// atrc_consts.vh: register map, field layout and reset values of the
// repetition counter and channel data block.
// assumes: included by bare name by every design file of the block.
`ifndef ATRC_CONSTS_VH
`define ATRC_CONSTS_VH

// register byte offsets, one aligned 32-bit word each
`define ATRC_OFS_RPT        8'h00
`define ATRC_OFS_CH1        8'h04
`define ATRC_OFS_CH2        8'h08
`define ATRC_OFS_CH3        8'h0c
`define ATRC_OFS_CH4        8'h10
`define ATRC_OFS_MODE       8'h14
`define ATRC_OFS_BUFEN      8'h18
`define ATRC_OFS_OUTCFG     8'h1c
`define ATRC_OFS_IRQ_STAT   8'h20
`define ATRC_OFS_IRQ_MASK   8'h24
`define ATRC_OFS_RCNT       8'h28
`define ATRC_ADDR_W         8

// repetition field
`define ATRC_RPT_W          8
`define ATRC_RPT_RST        8'h00

// channel data
`define ATRC_DATA_W         16
`define ATRC_DATA_RST       16'h0000

// output behaviour codes, two bits per channel
`define ATRC_OC_FROZEN      2'h0
`define ATRC_OC_MATCH_HI    2'h1
`define ATRC_OC_MATCH_LO    2'h2
`define ATRC_OC_TOGGLE      2'h3

// interrupt status layout: bit 0 overflow, bits 4..1 channel events
`define ATRC_IRQ_OVF        0
`define ATRC_IRQ_CH0        1
`define ATRC_IRQ_W          5

// axi responses
`define ATRC_RESP_OKAY      2'h0
`define ATRC_RESP_SLVERR    2'h2

`endif

// [hdl/atrc_channel.v]
// atrc_channel.v: one capture/compare channel with its data register,
// optional compare shadow and output shaping.
// assumes: counter value comes from the timer core and the overflow
// pulse from the repetition counter in atrc_top, all on ref_clk.
`timescale 1ns/10ps
`default_nettype none
`include "atrc_consts.vh"

module atrc_channel #(
    parameter DW = 16
) (
    // clock and reset
    input  wire          ref_clk,
    input  wire          arst_n,
    // timer core and repetition counter
    input  wire [DW-1:0] counter_value,
    input  wire          ovf_evt,
    // configuration
    input  wire          input_mode,
    input  wire          buf_en,
    input  wire [1:0]    out_cfg,
    // software write
    input  wire          wr_stb,
    input  wire [DW-1:0] wr_data,
    // pin side
    input  wire          chan_input_event,
    // results
    output reg  [DW-1:0] data_q,
    output reg           out_q,
    output reg           evt_q
);

    reg [DW-1:0] shadow_q;
    reg          shadow_pend_q;
    wire         match = (counter_value == data_q);

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            data_q        <= `ATRC_DATA_RST;
            shadow_q      <= `ATRC_DATA_RST;
            shadow_pend_q <= 1'b0;
            out_q         <= 1'b0;
            evt_q         <= 1'b0;
        end else begin
            evt_q <= 1'b0;
            if (input_mode) begin
                shadow_pend_q <= 1'b0;
                // a capture beats a software write in the same cycle
                if (chan_input_event) begin
                    data_q <= counter_value;
                    evt_q  <= 1'b1;
                end else if (wr_stb) begin
                    data_q <= wr_data;
                end
            end else begin
                if (wr_stb && !buf_en) begin
                    data_q        <= wr_data;
                    shadow_pend_q <= 1'b0;
                end else if (wr_stb) begin
                    shadow_q      <= wr_data;
                    shadow_pend_q <= 1'b1;
                end else if (ovf_evt && shadow_pend_q) begin
                    data_q        <= shadow_q;
                    shadow_pend_q <= 1'b0;
                end
                if (match) begin
                    evt_q <= 1'b1;
                    case (out_cfg)
                        `ATRC_OC_MATCH_HI: out_q <= 1'b1;
                        `ATRC_OC_MATCH_LO: out_q <= 1'b0;
                        `ATRC_OC_TOGGLE:   out_q <= ~out_q;
                        default:           out_q <= out_q;
                    endcase
                end
            end
        end
    end

endmodule // atrc_channel

`default_nettype wire

// [hdl/atrc_top.v]
// atrc_top.v: repetition counter and four channel data registers of an
// advanced 16-bit timer, reached over axi4-lite.
// assumes: counter value and period wrap pulse come from the timer core
// on ref_clk; channel input events are one-cycle synchronous pulses.
// unmapped words answer slverr and leave every register as it was.
//
// Chosen here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "atrc_consts.vh"

module atrc_top #(
    parameter DW   = 16,
    parameter NCH  = 4
) (
    // clock and reset
    input  wire                    ref_clk,
    input  wire                    arst_n,
    // axi4-lite write address
    input  wire [`ATRC_ADDR_W-1:0] s_axi_awaddr,
    input  wire                    s_axi_awvalid,
    output reg                     s_axi_awready,
    // axi4-lite write data
    input  wire [31:0]             s_axi_wdata,
    input  wire [3:0]              s_axi_wstrb,
    input  wire                    s_axi_wvalid,
    output reg                     s_axi_wready,
    // axi4-lite write response
    output reg  [1:0]              s_axi_bresp,
    output reg                     s_axi_bvalid,
    input  wire                    s_axi_bready,
    // axi4-lite read address
    input  wire [`ATRC_ADDR_W-1:0] s_axi_araddr,
    input  wire                    s_axi_arvalid,
    output reg                     s_axi_arready,
    // axi4-lite read data
    output reg  [31:0]             s_axi_rdata,
    output reg  [1:0]              s_axi_rresp,
    output reg                     s_axi_rvalid,
    input  wire                    s_axi_rready,
    // timer core
    input  wire [DW-1:0]           counter_value,
    input  wire                    period_wrap,
    output reg                     ovf_evt_q,
    // channel pins
    input  wire [NCH-1:0]          chan_input_event,
    output reg  [NCH-1:0]          chan_output,
    // interrupt
    output reg                     irq_q
);

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    reg  [`ATRC_RPT_W-1:0] repeat_count_value_q;
    // running repetition down-counter, also readable for debug
    reg  [`ATRC_RPT_W-1:0] rep_cnt_q;
    reg  [NCH-1:0]         mode_in_q;
    reg  [NCH-1:0]         buf_en_q;
    reg  [2*NCH-1:0]       out_cfg_q;
    reg  [`ATRC_IRQ_W-1:0] irq_stat_q;
    reg  [`ATRC_IRQ_W-1:0] irq_mask_q;

    // write address and data held until both are present
    reg  [`ATRC_ADDR_W-1:0] aw_addr_q;
    reg                     aw_have_q;
    reg  [31:0]             w_data_q;
    reg  [3:0]              w_strb_q;
    reg                     w_have_q;

    wire [NCH-1:0]    ch_wr;
    wire [DW*NCH-1:0] ch_data;
    wire [NCH-1:0]    ch_out;
    wire [NCH-1:0]    ch_evt;

    wire do_write = aw_have_q && w_have_q && !s_axi_bvalid;
    wire wr_lo    = w_strb_q[0];
    wire wr_hi    = w_strb_q[1];

    // ----------------------------------------------------------------
    // repetition counter
    // ----------------------------------------------------------------
    // the down-counter reloads at each overflow, so a new repetition
    // value takes effect only after the current run ends
    // it resets to zero, so the first wrap after reset already raises
    // an overflow event
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rep_cnt_q <= `ATRC_RPT_RST;
            ovf_evt_q <= 1'b0;
        end else begin
            ovf_evt_q <= 1'b0;
            if (period_wrap) begin
                if (rep_cnt_q == `ATRC_RPT_RST) begin
                    ovf_evt_q <= 1'b1;
                    rep_cnt_q <= repeat_count_value_q;
                end else begin
                    rep_cnt_q <= rep_cnt_q - 1'b1;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // channels
    // ----------------------------------------------------------------
    // capture, compare and shadow live in each channel; the top decodes
    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi = gi + 1) begin : g_ch
            // each channel decodes its own word from the base and the
            // stride; a data write needs both low byte lanes, since a
            // half-written compare value could raise a spurious match
            localparam [31:0] CH_OFS =
                `ATRC_OFS_CH1 + gi * (`ATRC_OFS_CH2 - `ATRC_OFS_CH1);
            wire [`ATRC_ADDR_W-1:0] ch_addr = CH_OFS[`ATRC_ADDR_W-1:0];
            assign ch_wr[gi] = do_write && wr_lo && wr_hi &&
                (aw_addr_q == ch_addr);
            atrc_channel #(.DW(DW)) u_ch (
                .ref_clk          (ref_clk),
                .arst_n           (arst_n),
                .counter_value    (counter_value),
                .ovf_evt          (ovf_evt_q),
                .input_mode       (mode_in_q[gi]),
                .buf_en           (buf_en_q[gi]),
                .out_cfg          (out_cfg_q[2*gi+1:2*gi]),
                .wr_stb           (ch_wr[gi]),
                .wr_data          (w_data_q[DW-1:0]),
                .chan_input_event (chan_input_event[gi]),
                .data_q           (ch_data[DW*gi+DW-1:DW*gi]),
                .out_q            (ch_out[gi]),
                .evt_q            (ch_evt[gi])
            );
        end
    endgenerate

    // outputs are held low in input mode; this extra stage keeps every
    // top output on a flip-flop, so a pin changes two edges after the
    // match that caused it
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            chan_output <= {NCH{1'b0}};
        end else begin
            chan_output <= ch_out & ~mode_in_q;
        end
    end

    // ----------------------------------------------------------------
    // axi4-lite write path
    // ----------------------------------------------------------------
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `ATRC_RESP_OKAY;
            aw_have_q     <= 1'b0;
            w_have_q      <= 1'b0;
            aw_addr_q     <= {`ATRC_ADDR_W{1'b0}};
            w_data_q      <= 32'h0000_0000;
            w_strb_q      <= 4'h0;
        end else begin
            // each ready pulses one cycle at a time and stays low while a
            // response is pending, so only one write is ever in flight;
            // address and data are parked until both have arrived
            s_axi_awready <= !aw_have_q && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready  <= !w_have_q && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q     <= 1'b1;
                aw_addr_q     <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q     <= 1'b1;
                w_data_q     <= s_axi_wdata;
                w_strb_q     <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            // registers change at the same edge that raises bvalid
            if (do_write) begin
                aw_have_q    <= 1'b0;
                w_have_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                case (aw_addr_q)
                    `ATRC_OFS_RPT, `ATRC_OFS_CH1, `ATRC_OFS_CH2,
                    `ATRC_OFS_CH3, `ATRC_OFS_CH4, `ATRC_OFS_MODE,
                    `ATRC_OFS_BUFEN, `ATRC_OFS_OUTCFG,
                    `ATRC_OFS_IRQ_STAT, `ATRC_OFS_IRQ_MASK,
                    `ATRC_OFS_RCNT:
                        s_axi_bresp <= `ATRC_RESP_OKAY;
                    default:
                        s_axi_bresp <= `ATRC_RESP_SLVERR;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // control registers; reserved repetition bits are never stored
    // channel data is written inside the channels; a word that is not
    // decoded here falls through and changes nothing
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            repeat_count_value_q <= `ATRC_RPT_RST;
            mode_in_q            <= {NCH{1'b0}};
            buf_en_q             <= {NCH{1'b0}};
            out_cfg_q            <= {2*NCH{1'b0}};
            irq_mask_q           <= {`ATRC_IRQ_W{1'b0}};
        end else if (do_write && wr_lo) begin
            case (aw_addr_q)
                `ATRC_OFS_RPT:
                    repeat_count_value_q <= w_data_q[`ATRC_RPT_W-1:0];
                `ATRC_OFS_MODE:     mode_in_q  <= w_data_q[NCH-1:0];
                `ATRC_OFS_BUFEN:    buf_en_q   <= w_data_q[NCH-1:0];
                `ATRC_OFS_OUTCFG:   out_cfg_q  <= w_data_q[2*NCH-1:0];
                `ATRC_OFS_IRQ_MASK:
                    irq_mask_q <= w_data_q[`ATRC_IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // interrupts
    // ----------------------------------------------------------------
    // set wins over a write-one clear in the same cycle
    // irq follows the masked status one edge later, so it too comes
    // straight from a flip-flop
    wire [`ATRC_IRQ_W-1:0] irq_set = {ch_evt, ovf_evt_q};
    wire [`ATRC_IRQ_W-1:0] irq_clr =
        (do_write && wr_lo && aw_addr_q == `ATRC_OFS_IRQ_STAT) ?
        w_data_q[`ATRC_IRQ_W-1:0] : {`ATRC_IRQ_W{1'b0}};

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_stat_q <= {`ATRC_IRQ_W{1'b0}};
            irq_q      <= 1'b0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
            irq_q      <= |(irq_stat_q & irq_mask_q);
        end
    end

    // ----------------------------------------------------------------
    // axi4-lite read path
    // ----------------------------------------------------------------
    // the mux looks at araddr directly and is sampled at the edge that
    // takes the address, so rdata and rresp stand with rvalid and do
    // not follow later register changes
    reg [31:0] rd_mux;
    reg        rd_err;
    always @* begin
        rd_mux = 32'h0000_0000;
        rd_err = 1'b0;
        case (s_axi_araddr)
            `ATRC_OFS_RPT:  rd_mux[`ATRC_RPT_W-1:0] = repeat_count_value_q;
            `ATRC_OFS_CH1:  rd_mux[DW-1:0] = ch_data[DW-1:0];
            `ATRC_OFS_CH2:  rd_mux[DW-1:0] = ch_data[2*DW-1:DW];
            `ATRC_OFS_CH3:  rd_mux[DW-1:0] = ch_data[3*DW-1:2*DW];
            `ATRC_OFS_CH4:  rd_mux[DW-1:0] = ch_data[4*DW-1:3*DW];
            `ATRC_OFS_MODE:     rd_mux[NCH-1:0] = mode_in_q;
            `ATRC_OFS_BUFEN:    rd_mux[NCH-1:0] = buf_en_q;
            `ATRC_OFS_OUTCFG:   rd_mux[2*NCH-1:0] = out_cfg_q;
            `ATRC_OFS_IRQ_STAT: rd_mux[`ATRC_IRQ_W-1:0] = irq_stat_q;
            `ATRC_OFS_IRQ_MASK: rd_mux[`ATRC_IRQ_W-1:0] = irq_mask_q;
            `ATRC_OFS_RCNT:     rd_mux[`ATRC_RPT_W-1:0] = rep_cnt_q;
            default:            rd_err = 1'b1;
        endcase
    end

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `ATRC_RESP_OKAY;
        end else begin
            // arready rises only while arvalid is up, one cycle at a time
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid &&
                             s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid  <= 1'b1;
                s_axi_arready <= 1'b0;
                s_axi_rdata   <= rd_mux;
                s_axi_rresp   <= rd_err ? `ATRC_RESP_SLVERR :
                                          `ATRC_RESP_OKAY;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule // atrc_top

`default_nettype wire

// [verification/atrc_props.sv]
// atrc_props.sv: timing and bus properties of atrc_top at its ports.
// assumes: bound to atrc_top from the bench top file, one clock domain.
`timescale 1ns/10ps
`default_nettype none
`include "atrc_consts.vh"
module atrc_props #(
    parameter DW  = 16,
    parameter NCH = 4
) (
    // clock and reset
    input wire logic                    ref_clk,
    input wire logic                    arst_n,
    // register bus
    input wire logic [`ATRC_ADDR_W-1:0] s_axi_awaddr,
    input wire logic                    s_axi_awvalid,
    input wire logic                    s_axi_awready,
    input wire logic [31:0]             s_axi_wdata,
    input wire logic [3:0]              s_axi_wstrb,
    input wire logic                    s_axi_wvalid,
    input wire logic                    s_axi_wready,
    input wire logic [1:0]              s_axi_bresp,
    input wire logic                    s_axi_bvalid,
    input wire logic                    s_axi_bready,
    input wire logic [`ATRC_ADDR_W-1:0] s_axi_araddr,
    input wire logic                    s_axi_arvalid,
    input wire logic                    s_axi_arready,
    input wire logic [31:0]             s_axi_rdata,
    input wire logic [1:0]              s_axi_rresp,
    input wire logic                    s_axi_rvalid,
    input wire logic                    s_axi_rready,
    // timer side
    input wire logic [DW-1:0]           counter_value,
    input wire logic                    period_wrap,
    input wire logic                    ovf_evt_q,
    input wire logic [NCH-1:0]          chan_input_event,
    input wire logic [NCH-1:0]          chan_output,
    input wire logic                    irq_q
);
    logic [8:0] wraps_q;
    // ----------------------------------------
    // wraps seen since the last overflow
    // ----------------------------------------
    // an 8-bit repeat value allows at most 256 wraps per overflow
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n)
            wraps_q <= 9'h000;
        else if (ovf_evt_q)
            wraps_q <= 9'h000;
        else if (period_wrap)
            wraps_q <= wraps_q + 9'h001;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    chk_ovf_after_wrap:
        assert property (ovf_evt_q |-> $past(period_wrap))
        else $error("overflow without a period wrap");
    chk_ovf_spacing:
        assert property (wraps_q <= 9'h100)
        else $error("too many wraps without overflow");
    chk_rpt_reserved:
        assert property (s_axi_arvalid && s_axi_arready
            && s_axi_araddr == `ATRC_OFS_RPT |-> ##[1:2]
            s_axi_rvalid && s_axi_rdata[15:8] == 8'h00)
        else $error("reserved repeat bits not zero");
    chk_bresp_hold:
        assert property (s_axi_bvalid && !s_axi_bready |=>
            s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    chk_rdata_hold:
        assert property (s_axi_rvalid && !s_axi_rready |=>
            s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    chk_write_answer:
        assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
            && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write not answered");
    chk_read_answer:
        assert property (s_axi_arvalid && s_axi_arready
            |-> ##[1:2] s_axi_rvalid)
        else $error("read not answered");
    chk_unmapped_err:
        assert property (s_axi_arvalid && s_axi_arready
            && s_axi_araddr > `ATRC_OFS_RCNT |-> ##[1:2]
            s_axi_rvalid && s_axi_rresp == `ATRC_RESP_SLVERR)
        else $error("unmapped read not refused");
    chk_aw_idle:
        assert property (s_axi_awready |-> !s_axi_bvalid)
        else $error("write taken while response pending");
    cover property (ovf_evt_q);
    cover property ($rose(irq_q));
    cover property ($rose(|chan_output));
endmodule // atrc_props
`default_nettype wire

// [verification/adv_timer_repeat_and_ccr_tb.sv]
// adv_timer_repeat_and_ccr_tb.sv: self-checking bench for atrc_top.
// assumes: the bench drives the bus and the timer core signals itself.
`timescale 1ns/10ps
`default_nettype none
`include "atrc_consts.vh"
module adv_timer_repeat_and_ccr_tb;
    logic        ref_clk = 1'b0, arst_n = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
    logic [3:0]  s_axi_wstrb = 4'hf, chan_input_event = 4'h0;
    logic [3:0]  chan_output, expo;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0, period_wrap = 1'b0, done;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, ovf_evt_q, irq_q;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic [15:0] counter_value = 16'hffff, d [4], cv [4], nv;
    int          err_count = 0, n_compared = 0, n_ovf = 0, base, v;
    atrc_top #(.DW(16), .NCH(4)) u_dut (.*);
    always #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (ovf_evt_q) n_ovf <= n_ovf + 1;
    task chk(input string what, input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    // ----------------------------------------
    // bus tasks: response ready stalls at random to exercise holding
    // ----------------------------------------
    task wr(input logic [7:0] a, input logic [31:0] dat);
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= dat;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'($urandom);
        do begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            resp = s_axi_bresp;
            done = s_axi_bvalid && s_axi_bready;
            if (!s_axi_bready) s_axi_bready <= 1'($urandom);
        end while (!done);
        s_axi_bready <= 1'b0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'($urandom);
        do begin
            @(posedge ref_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            rdat = s_axi_rdata;
            resp = s_axi_rresp;
            done = s_axi_rvalid && s_axi_rready;
            if (!s_axi_rready) s_axi_rready <= 1'($urandom);
        end while (!done);
        s_axi_rready <= 1'b0;
    endtask
    task pulse_wrap;
        @(posedge ref_clk) period_wrap <= 1'b1;
        @(posedge ref_clk) period_wrap <= 1'b0;
    endtask
    function logic nxt(input int code, input logic o);
        case (code)
            1: nxt = 1'b1;
            2: nxt = 1'b0;
            3: nxt = !o;
            default: nxt = o;
        endcase
    endfunction
    task wrap_up;
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_count++;
        wrap_up;
    end
    initial begin
        void'($urandom(32'hbab8b5b6));
        repeat (12) @(posedge ref_clk);
        arst_n <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            rd(8'(4 * i));
            chk("reset value", rdat, 32'h0);
        end
        v = $urandom % 8;
        wr(`ATRC_OFS_RPT, 32'h0000ff00 | v);
        rd(`ATRC_OFS_RPT);
        chk("repeat value", rdat, v);
        base = n_ovf;
        // first wrap fires at once: the down-counter starts at zero
        repeat (1 + 4 * (v + 1)) pulse_wrap;
        repeat (2) @(posedge ref_clk);
        chk("overflow count", n_ovf - base, 5);
        rd(`ATRC_OFS_RCNT);
        chk("down-counter reload", rdat, v);
        $display("test repetition done");
        wr(`ATRC_OFS_IRQ_STAT, 32'h1f);
        wr(`ATRC_OFS_MODE, 32'hf);
        wr(`ATRC_OFS_IRQ_MASK, 32'h1e);
        for (int i = 0; i < 4; i++) begin
            cv[i] = 16'($urandom);
            @(posedge ref_clk) counter_value <= cv[i];
            @(posedge ref_clk) chan_input_event <= 4'(1 << i);
            @(posedge ref_clk) chan_input_event <= 4'h0;
        end
        counter_value <= 16'hffff;
        for (int i = 0; i < 4; i++) begin
            rd(`ATRC_OFS_CH1 + 8'(4 * i));
            chk("capture", rdat, cv[i]);
        end
        chk("irq raised", irq_q, 1);
        wr(`ATRC_OFS_IRQ_MASK, 32'h0);
        repeat (2) @(posedge ref_clk);
        chk("irq masked", irq_q, 0);
        rd(`ATRC_OFS_IRQ_STAT);
        chk("status", rdat, 32'h1e);
        wr(`ATRC_OFS_IRQ_STAT, 32'h1e);
        rd(`ATRC_OFS_IRQ_STAT);
        chk("status cleared", rdat, 32'h0);
        $display("test capture done");
        wr(`ATRC_OFS_MODE, 32'h0);
        for (int i = 0; i < 4; i++) begin
            d[i] = {1'b0, 13'($urandom), 2'(i)};
            wr(`ATRC_OFS_CH1 + 8'(4 * i), {16'h0, d[i]});
            rd(`ATRC_OFS_CH1 + 8'(4 * i));
            chk("data", rdat, d[i]);
        end
        expo = 4'h0;
        for (int code = 0; code < 4; code++) begin
            wr(`ATRC_OFS_OUTCFG, {24'h0, {4{2'(code)}}});
            for (int i = 0; i < 4; i++) begin
                @(posedge ref_clk) counter_value <= d[i];
                @(posedge ref_clk) counter_value <= 16'hffff;
                repeat (3) @(posedge ref_clk);
                expo[i] = nxt(code, expo[i]);
            end
            chk("outputs", chan_output, expo);
        end
        $display("test compare done");
        wr(`ATRC_OFS_RPT, 32'h0);
        wr(`ATRC_OFS_BUFEN, 32'h1);
        nv = d[0] ^ 16'h0f0f;
        wr(`ATRC_OFS_CH1, {16'h0, nv});
        rd(`ATRC_OFS_CH1);
        chk("held in shadow", rdat, d[0]);
        repeat (9) pulse_wrap;
        rd(`ATRC_OFS_CH1);
        chk("moved at overflow", rdat, nv);
        wr(`ATRC_OFS_BUFEN, 32'h0);
        wr(`ATRC_OFS_CH1, {16'h0, d[1]});
        rd(`ATRC_OFS_CH1);
        chk("direct write", rdat, d[1]);
        s_axi_wstrb <= 4'h1;
        wr(`ATRC_OFS_CH1, {16'h0, d[2]});
        chk("partial write resp", resp, `ATRC_RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        rd(`ATRC_OFS_CH1);
        chk("partial write ignored", rdat, d[1]);
        rd(8'h2c);
        chk("unmapped read", resp, `ATRC_RESP_SLVERR);
        wr(8'h30, 32'hffffffff);
        chk("unmapped write", resp, `ATRC_RESP_SLVERR);
        $display("test buffering and bus done");
        wrap_up;
    end
endmodule // adv_timer_repeat_and_ccr_tb
bind atrc_top atrc_props #(.DW(DW), .NCH(NCH)) u_props (.*);
`default_nettype wire
